// ### rtl/aacd_top.sv
// Register file and converter/modulator clock dividers of the audio converter clock tree.
// Assumes the control bus front end has selected page 0 and presents single-cycle strobes;
// the divider source clocks arrive as one-cycle enable pulses on clk_i.
//
// What this block does
// - Fraction high byte holds bits 13..8 in six low bits; top two reserved.
// - Fraction low byte holds bits 7..0 and resets to zero.
// - High byte takes effect only when low byte is the very next write.
// - Converter divider bit 7 powers it: 0 down, 1 up; reset down.
// - Converter divider divides by field, zero means 128; resets to 1.
// - Modulator divider bit 7 powers it: 0 down, 1 up; reset down.
// - Modulator divider divides by field, zero means 128; resets to 1.
// - Oversampling ratio 8 bits, zero means 256; resets to 128.
// - Filter instruction count is twice the field; zero reserved; reset 256.
// - Decimation ratio 4 bits, zero means 16, reset 4; upper nibble reads zero.
// - Clock output source select: three bits, five valid codes, reset 000.
`timescale 1ns/10ps
module aacd_top #(
   parameter int DIV_WIDTH = 7
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire aacd_pkg::aacd_req_t req_i,
   input wire logic converter_src_en_i,
   input wire logic modulator_src_en_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   output aacd_pkg::aacd_cfg_t cfg_o,
   output logic converter_clk_en_o,
   output logic modulator_clock_en_o
);
   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   logic [7:0] frac_high_reg;
   logic [7:0] frac_high_pend_reg;
   logic [7:0] frac_low_reg;
   logic high_pending_reg;
   logic [7:0] conv_div_reg;
   logic [7:0] mod_div_reg;
   logic [7:0] osr_reg;
   logic [7:0] instr_reg;
   logic [3:0] decim_reg;
   logic [2:0] src_reg;
   logic wr_high;
   logic wr_low;

   assign wr_high = req_i.wr && (req_i.addr == aacd_pkg::OFS_PLL_FRACTION_HIGH);
   assign wr_low = req_i.wr && (req_i.addr == aacd_pkg::OFS_PLL_FRACTION_LOW);

   // ----------------------------------------
   // Fractional multiplier, ordered two-byte load
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         frac_high_pend_reg <= aacd_pkg::RST_PLL_FRACTION_HIGH;
         frac_high_reg <= aacd_pkg::RST_PLL_FRACTION_HIGH;
         frac_low_reg <= aacd_pkg::RST_PLL_FRACTION_LOW;
         high_pending_reg <= 1'b0;
      end
      else if (req_i.wr)
      begin
         // Any write other than the low byte drops a pending high byte
         high_pending_reg <= wr_high;
         if (wr_high)
         begin
            frac_high_pend_reg <= req_i.wdata & aacd_pkg::FRACTION_HIGH_MASK;
         end
         if (wr_low)
         begin
            frac_low_reg <= req_i.wdata;
            // Low byte applies at once; the high byte only if it was the last write
            if (high_pending_reg)
            begin
               frac_high_reg <= frac_high_pend_reg;
            end
         end
      end
   end

   // ----------------------------------------
   // Divider and filter configuration registers
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         conv_div_reg <= aacd_pkg::RST_DIVIDER;
         mod_div_reg <= aacd_pkg::RST_DIVIDER;
         osr_reg <= aacd_pkg::RST_OVERSAMPLING;
         instr_reg <= aacd_pkg::RST_FILTER_INSTR;
         decim_reg <= aacd_pkg::RST_FILTER_DECIM;
         src_reg <= aacd_pkg::RST_CLOCK_OUT_SRC;
      end
      else if (req_i.wr)
      begin
         case (req_i.addr)
            aacd_pkg::OFS_CONVERTER_DIV: conv_div_reg <= req_i.wdata;
            aacd_pkg::OFS_MODULATOR_DIV: mod_div_reg <= req_i.wdata;
            aacd_pkg::OFS_OVERSAMPLING: osr_reg <= req_i.wdata;
            aacd_pkg::OFS_FILTER_INSTR: instr_reg <= req_i.wdata;
            aacd_pkg::OFS_FILTER_DECIM: decim_reg <= req_i.wdata[3:0];
            aacd_pkg::OFS_CLOCK_OUT_SRC: src_reg <= req_i.wdata[2:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Read-back
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdata_o <= 8'h00;
         rvalid_o <= 1'b0;
      end
      else
      begin
         rvalid_o <= req_i.rd;
         if (req_i.rd)
         begin
            case (req_i.addr)
               aacd_pkg::OFS_PLL_FRACTION_HIGH: rdata_o <= frac_high_reg;
               aacd_pkg::OFS_PLL_FRACTION_LOW: rdata_o <= frac_low_reg;
               aacd_pkg::OFS_CONVERTER_DIV: rdata_o <= conv_div_reg;
               aacd_pkg::OFS_MODULATOR_DIV: rdata_o <= mod_div_reg;
               aacd_pkg::OFS_OVERSAMPLING: rdata_o <= osr_reg;
               aacd_pkg::OFS_FILTER_INSTR: rdata_o <= instr_reg;
               aacd_pkg::OFS_FILTER_DECIM: rdata_o <= {4'h0, decim_reg};
               aacd_pkg::OFS_CLOCK_OUT_SRC: rdata_o <= {5'h00, src_reg};
               default: rdata_o <= aacd_pkg::READ_UNDEFINED;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Decoded configuration outputs
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg_o <= '0;
      end
      else
      begin
         cfg_o.pll_fraction_value <= {frac_high_reg[5:0], frac_low_reg};
         cfg_o.oversampling_ratio <= (osr_reg == 8'h00) ? 9'h100 : {1'b0, osr_reg};
         cfg_o.filter_instruction_count <= {instr_reg, 1'b0};
         cfg_o.decimation_ratio <= (decim_reg == 4'h0) ? 5'h10 : {1'b0, decim_reg};
         cfg_o.clock_output_divider_input <= src_reg;
      end
   end

   // ----------------------------------------
   // Converter and modulator dividers
   // ----------------------------------------
   logic [1:0] src_en;
   logic [1:0] div_en_pulse;
   logic [7:0] div_cfg [2];

   assign src_en = {modulator_src_en_i, converter_src_en_i};
   assign div_cfg[0] = conv_div_reg;
   assign div_cfg[1] = mod_div_reg;

   for (genvar g = 0; g < 2; g++)
   begin : g_div
      logic [DIV_WIDTH-1:0] cnt_reg;
      logic pulse_reg;
      logic powered;
      logic [DIV_WIDTH-1:0] last;
      assign powered = div_cfg[g][aacd_pkg::DIV_POWER_BIT];
      // Field zero wraps to all ones, a divide by 128
      assign last = div_cfg[g][DIV_WIDTH-1:0] - 1'b1;
      always_ff @(posedge clk_i)
      begin
         if (rst_i)
         begin
            cnt_reg <= '0;
            pulse_reg <= 1'b0;
         end
         else if (!powered)
         begin
            // Count is held so a re-powered divider resumes where it stopped
            pulse_reg <= 1'b0;
         end
         else if (src_en[g])
         begin
            if (cnt_reg >= last)
            begin
               cnt_reg <= '0;
               pulse_reg <= 1'b1;
            end
            else
            begin
               cnt_reg <= cnt_reg + 1'b1;
               pulse_reg <= 1'b0;
            end
         end
         else
         begin
            pulse_reg <= 1'b0;
         end
      end
      assign div_en_pulse[g] = pulse_reg;
   end

   assign converter_clk_en_o = div_en_pulse[0];
   assign modulator_clock_en_o = div_en_pulse[1];
endmodule

// ### rtl/aacd_pkg.sv
// Package for the audio converter clock divider and configuration block.
// Assumes a byte-wide register port already decoded from the control bus.
package aacd_pkg;
   // ----------------------------------------
   // Register offsets (page 0)
   // ----------------------------------------
   localparam logic [7:0] OFS_PLL_FRACTION_HIGH = 8'h07;
   localparam logic [7:0] OFS_PLL_FRACTION_LOW = 8'h08;
   localparam logic [7:0] OFS_CONVERTER_DIV = 8'h12;
   localparam logic [7:0] OFS_MODULATOR_DIV = 8'h13;
   localparam logic [7:0] OFS_OVERSAMPLING = 8'h14;
   localparam logic [7:0] OFS_FILTER_INSTR = 8'h15;
   localparam logic [7:0] OFS_FILTER_DECIM = 8'h16;
   localparam logic [7:0] OFS_CLOCK_OUT_SRC = 8'h19;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] RST_PLL_FRACTION_HIGH = 8'h00;
   localparam logic [7:0] RST_PLL_FRACTION_LOW = 8'h00;
   localparam logic [7:0] RST_DIVIDER = 8'h01;
   localparam logic [7:0] RST_OVERSAMPLING = 8'h80;
   localparam logic [7:0] RST_FILTER_INSTR = 8'h80;
   localparam logic [3:0] RST_FILTER_DECIM = 4'h4;
   localparam logic [2:0] RST_CLOCK_OUT_SRC = 3'h0;
   // ----------------------------------------
   // Field layouts and masks
   // ----------------------------------------
   localparam int DIV_POWER_BIT = 7;
   localparam logic [7:0] FRACTION_HIGH_MASK = 8'h3F;
   localparam logic [7:0] READ_UNDEFINED = 8'h00;
   // ----------------------------------------
   // Clock output source codes
   // ----------------------------------------
   typedef enum logic [2:0] {
      AACD_SRC_MASTER_PIN = 3'h0,
      AACD_SRC_BIT_CLOCK_PIN = 3'h1,
      AACD_SRC_PLL = 3'h3,
      AACD_SRC_CONVERTER = 3'h6,
      AACD_SRC_MODULATOR = 3'h7
   } aacd_src_t;
   // ----------------------------------------
   // Register request carrier, write and read
   // ----------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } aacd_req_t;
   // ----------------------------------------
   // Decoded configuration seen by the clock tree
   // ----------------------------------------
   typedef struct packed {
      logic [13:0] pll_fraction_value;
      logic [8:0] oversampling_ratio;
      logic [8:0] filter_instruction_count;
      logic [4:0] decimation_ratio;
      logic [2:0] clock_output_divider_input;
   } aacd_cfg_t;
endpackage

// ### tb/aacd_monitor.sv
// Checker for the clock divider register block, bound to aacd_top.
// Sees only top ports; everything runs on clk_i with rst_i as the disable.
`timescale 1ns/10ps
module aacd_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire aacd_pkg::aacd_req_t req_i,
   input wire aacd_pkg::aacd_cfg_t cfg_o,
   input wire logic converter_clk_en_o,
   input wire logic modulator_clock_en_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic [7:0] wd = req_i.wdata;
   sequence s_w(logic [7:0] a);
      req_i.wr && req_i.addr == a;
   endsequence
   sequence s_high;
      s_w(8'h07) ##1 !req_i.wr;
   endsequence
   property p_pair;
      s_high ##1 s_w(8'h08) |->
         ##2 cfg_o.pll_fraction_value == {$past(wd[5:0], 4), $past(wd, 2)};
   endproperty
   a_pair: assert property (p_pair) else $error("fraction pair not applied");
   property p_orphan;
      s_high ##1 (req_i.wr && req_i.addr != 8'h08) |->
         ##2 cfg_o.pll_fraction_value[13:8] == $past(cfg_o.pll_fraction_value[13:8], 4);
   endproperty
   a_orphan: assert property (p_orphan) else $error("lone high byte applied");
   property p_osr;
      s_w(8'h14) |->
         ##2 cfg_o.oversampling_ratio == ($past(wd, 2) == 8'h00 ? 9'h100 : {1'b0, $past(wd, 2)});
   endproperty
   a_osr: assert property (p_osr) else $error("oversampling ratio wrong");
   property p_instr;
      s_w(8'h15) |-> ##2 cfg_o.filter_instruction_count == {$past(wd, 2), 1'b0};
   endproperty
   a_instr: assert property (p_instr) else $error("instruction count wrong");
   property p_decim;
      s_w(8'h16) |->
         ##2 cfg_o.decimation_ratio ==
            ($past(wd[3:0], 2) == 4'h0 ? 5'h10 : {1'b0, $past(wd[3:0], 2)});
   endproperty
   a_decim: assert property (p_decim) else $error("decimation ratio wrong");
   property p_src;
      s_w(8'h19) |-> ##2 cfg_o.clock_output_divider_input == $past(wd[2:0], 2);
   endproperty
   a_src: assert property (p_src) else $error("clock output source wrong");
   property p_conv_off;
      s_w(8'h12) ##0 !wd[7] ##1 !req_i.wr |=> !converter_clk_en_o;
   endproperty
   a_conv_off: assert property (p_conv_off) else $error("converter pulse while off");
   property p_mod_off;
      s_w(8'h13) ##0 !wd[7] ##1 !req_i.wr |=> !modulator_clock_en_o;
   endproperty
   a_mod_off: assert property (p_mod_off) else $error("modulator pulse while off");
endmodule

// ### tb/aacd_host.sv
// Host model on the register port: one request at a time, idle cycle between.
// Notes each expected read value in exp_q for the bench's read watcher.
`timescale 1ns/10ps
module aacd_host (
   input wire logic clk_i,
   output aacd_pkg::aacd_req_t req_o
);
   logic [7:0] exp_q[$];
   initial req_o = '0;
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req_o <= '{w, !w, a, w ? d : 8'h00};
      if (!w)
         exp_q.push_back(d);
      @(posedge clk_i);
      req_o <= '0;
   endtask
endmodule

// ### tb/test_audio_adc_clock_divider_config.sv
// Self-checking bench for the clock divider register block.
// Host model drives the register port; the checker is bound to aacd_top.
`timescale 1ns/10ps
module test_audio_adc_clock_divider_config;
   logic clk_i = 1'b0, rst_i = 1'b1, conv_src = 1'b0, mod_src = 1'b0;
   logic rvalid, conv_en, mod_en;
   logic [7:0] rdata, d;
   aacd_pkg::aacd_req_t req;
   aacd_pkg::aacd_cfg_t cfg;
   int error_cnt = 0, n_checks = 0;
   logic [15:0] rst_tab[9] = '{16'h0700, 16'h0800, 16'h1201, 16'h1301, 16'h1480,
      16'h1580, 16'h1604, 16'h1900, 16'h0900};
   logic [2:0] codes[5] = '{3'h0, 3'h1, 3'h3, 3'h6, 3'h7};
   always #25 clk_i = ~clk_i;
   aacd_host aacd_host_inst (.clk_i(clk_i), .req_o(req));
   aacd_top #(.DIV_WIDTH(7)) aacd_top_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
      .converter_src_en_i(conv_src), .modulator_src_en_i(mod_src), .rdata_o(rdata),
      .rvalid_o(rvalid), .cfg_o(cfg), .converter_clk_en_o(conv_en),
      .modulator_clock_en_o(mod_en));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      error_cnt += int'(seen !== exp);
      if (seen !== exp)
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
   endtask
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, d);
      aacd_host_inst.xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, e);
      aacd_host_inst.xfer(1'b0, a, e);
   endtask
   always @(negedge clk_i)
      if (rvalid === 1'b1)
         check({8'h00, rdata}, {8'h00, aacd_host_inst.exp_q.pop_front()});
   // Counts output pulses over n full periods with the chosen source held high
   task automatic div(input bit m, input logic [7:0] v, input int n);
      int cnt;
      cnt = 0;
      wr(m ? 8'h13 : 8'h12, v);
      conv_src <= !m;
      mod_src <= m;
      repeat (n * ((v[6:0] == 7'h00) ? 128 : int'(v[6:0])) + 1)
      begin
         @(negedge clk_i);
         cnt += int'((m ? mod_en : conv_en) === 1'b1);
      end
      @(posedge clk_i);
      conv_src <= 1'b0;
      mod_src <= 1'b0;
      check(cnt[15:0], v[7] ? n[15:0] : 16'h0000);
   endtask
   initial
   begin
      void'($urandom(32'hB812));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rst_tab[i])
         rd(rst_tab[i][15:8], rst_tab[i][7:0]);
      check({7'h00, cfg.oversampling_ratio}, 16'h0080);
      check({7'h00, cfg.filter_instruction_count}, 16'h0100);
      check({11'h000, cfg.decimation_ratio}, 16'h0004);
      wr(8'h07, 8'hD5);
      wr(8'h08, 8'hAA);
      repeat (2) @(negedge clk_i);
      check({2'b00, cfg.pll_fraction_value}, 16'h15AA);
      rd(8'h07, 8'h15);
      // Lone high byte, followed by another register
      wr(8'h07, 8'h3F);
      wr(8'h16, 8'h02);
      rd(8'h07, 8'h15);
      // A later lone low byte must not bring the dropped high byte along
      wr(8'h08, 8'h55);
      repeat (2) @(negedge clk_i);
      check({2'b00, cfg.pll_fraction_value}, 16'h1555);
      foreach (codes[i])
      begin
         d = (i == 0) ? 8'h00 : 8'($urandom) & 8'hFE;
         wr(8'h14, d);
         wr(8'h19, {5'h00, codes[i]});
         rd(8'h14, d);
         rd(8'h19, {5'h00, codes[i]});
      end
      wr(8'h15, 8'hFF);
      rd(8'h15, 8'hFF);
      rd(8'h16, 8'h02);
      // Ratio and count of 256 first, so a decimation of 16 divides both
      wr(8'h14, 8'h00);
      wr(8'h15, 8'h80);
      wr(8'h16, 8'h00);
      rd(8'h16, 8'h00);
      @(negedge clk_i);
      check({11'h000, cfg.decimation_ratio}, 16'h0010);
      $display("Register tests done");
      div(1'b0, 8'h83, 4);
      div(1'b0, 8'h80, 2);
      div(1'b0, 8'h03, 4);
      div(1'b1, 8'h82, 5);
      div(1'b1, 8'h02, 3);
      $display("Divider tests done");
      repeat (4) @(posedge clk_i);
      check(16'(aacd_host_inst.exp_q.size()), 16'h0000);
      stop_test();
   end
endmodule
bind aacd_top aacd_monitor aacd_monitor_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
   .cfg_o(cfg_o), .converter_clk_en_o(converter_clk_en_o),
   .modulator_clock_en_o(modulator_clock_en_o));
